// ==== rtl/tmo_output_paths.sv ====
// Output paths of a T1 monitor: data link output, one second timer, grouped
// interrupt request and transmit data stream multiplexer with loopback codes.
// Assumes bit clock, frame pulse and serial inputs arrive from outside the
// system clock domain; registers are reached over APB.
//
// Summary of operation
// - With message mode on, the link output shifts an FF flag then the message byte.
// - With message mode off, the link input reaches the link output with no re-timing.
// - A one second square wave, half low then half high, is made from the frame pulse.
// - The interrupt pin is open drain: driven low to request, else released.
// - Writing the acknowledge bit low makes the device release the interrupt pin.
// - After acknowledge a group may not request again until all its sources go idle.
// - The transmit output is a 2.048 Mbit/s stream carrying the 24 trunk channels.
// - Normal mode sends the first data input, payload loopback the second.
// - Loop code generation fills the 24 trunk channels with the up or down code.
// - While reset is asserted every function but the link pass-through is held in its idle state.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps

module tmo_output_paths #(
  parameter int G1_WIDTH = 4,
  parameter int G2_WIDTH = 4
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                bit_clock_in,
  input  wire logic                frame_pulse_n_in,
  input  wire logic                link_data_in,
  output logic                     link_data_out,
  input  wire logic                tx_data_normal_in,
  input  wire logic                tx_data_loopback_in,
  output logic                     tx_data_out,
  output logic                     one_second_out,
  output logic                     irq_pin_out,
  output logic                     irq_pin_oe_n,
  output logic                     irq_line,
  input  wire logic [G1_WIDTH-1:0] g1_sources,
  input  wire logic [G2_WIDTH-1:0] g2_sources
);

  // ==========================================================================
  // Pin synchronisers: three stages, level moves when stages two and three agree
  localparam int NSYNC = 5;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_lvl;
  logic             bclk_prev;
  logic             frm_prev;
  logic             bit_rise;
  logic             frame_start;

  assign pin_raw = {tx_data_loopback_in, tx_data_normal_in, link_data_in,
                    frame_pulse_n_in, bit_clock_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic [2:0] stg;
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          stg <= 3'h7;
        end else begin
          stg <= {stg[1:0], pin_raw[gi]};
        end
      end
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pin_lvl[gi] <= 1'b1;
        end else if (stg[1] == stg[2]) begin
          pin_lvl[gi] <= stg[2];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bclk_prev <= 1'b1;
      frm_prev  <= 1'b1;
    end else begin
      bclk_prev <= pin_lvl[0];
      frm_prev  <= pin_lvl[1];
    end
  end

  assign bit_rise    = pin_lvl[0] & ~bclk_prev;
  assign frame_start = ~pin_lvl[1] & frm_prev;

  // ==========================================================================
  // Registers
  logic [1:0]  ctrl;
  logic [7:0]  bit_oriented_message;
  logic [1:0]  loop_req;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;
  logic [3:0]  ev;
  logic        acc;
  logic        wr_go;
  tmo_pkg::tmo_mode_t mode;
  logic        ack_f;
  logic [1:0]  armed;
  logic [1:0]  pend;
  logic        sec_tick;
  logic        bom_done;

  // Access phase gets one wait cycle so read data can come from a flip-flop
  assign acc   = psel & penable;
  assign wr_go = acc & pready & pwrite;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (acc & ~pready) begin
        if (paddr == tmo_pkg::CTRL_OFS) begin
          prdata <= {30'h0, ctrl};
        end else if (paddr == tmo_pkg::BOM_OFS) begin
          prdata <= {24'h0, bit_oriented_message};
        end else if (paddr == tmo_pkg::LOOP_OFS) begin
          prdata <= {30'h0, loop_req};
        end else if (paddr == tmo_pkg::IRQ_STAT_OFS) begin
          prdata <= {28'h0, irq_stat};
        end else if (paddr == tmo_pkg::IRQ_MASK_OFS) begin
          prdata <= {28'h0, irq_mask};
        end else if (paddr == tmo_pkg::STATE_OFS) begin
          prdata <= {25'h0, one_second_out, mode, armed, pend};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl     <= tmo_pkg::CTRL_RESET;
      bit_oriented_message      <= tmo_pkg::BOM_RESET;
      loop_req <= tmo_pkg::LOOP_RESET;
      irq_mask <= tmo_pkg::IRQ_MASK_RESET;
    end else if (wr_go) begin
      if (paddr == tmo_pkg::CTRL_OFS) begin
        ctrl <= pwdata[1:0];
      end else if (paddr == tmo_pkg::BOM_OFS) begin
        bit_oriented_message <= pwdata[7:0];
      end else if (paddr == tmo_pkg::LOOP_OFS) begin
        loop_req <= pwdata[1:0];
      end else if (paddr == tmo_pkg::IRQ_MASK_OFS) begin
        irq_mask <= pwdata[3:0];
      end
    end
  end

  // ==========================================================================
  // Event status, write one to clear; a new event wins over the clear
  assign ev = {bom_done, ack_f & armed[1] & (|g2_sources),
               ack_f & armed[0] & (|g1_sources), sec_tick};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat <= 4'h0;
      irq_line <= 1'b0;
    end else begin
      if (wr_go && paddr == tmo_pkg::IRQ_STAT_OFS) begin
        irq_stat <= (irq_stat & ~pwdata[3:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      irq_line <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================================
  // Frame boundary sampling of acknowledge and loopback mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode  <= tmo_pkg::TMO_NORMAL;
      ack_f <= 1'b0;
    end else if (frame_start) begin
      mode  <= tmo_pkg::tmo_mode_t'(loop_req);
      ack_f <= ctrl[tmo_pkg::CTRL_ACK_BIT];
    end
  end

  // ==========================================================================
  // Grouped interrupt request
  logic [1:0] grp_any;
  assign grp_any = {|g2_sources, |g1_sources};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      armed <= 2'b11;
      pend  <= 2'b00;
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (!ack_f) begin
          pend[g]  <= 1'b0;
          armed[g] <= armed[g] & ~pend[g];
        end else if (armed[g] && grp_any[g]) begin
          pend[g]  <= 1'b1;
          armed[g] <= 1'b0;
        end else if (!pend[g] && !grp_any[g]) begin
          armed[g] <= 1'b1;
        end
      end
    end
  end

  // Pin only pulled low, never driven high; pull-up makes the high level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_pin_out  <= 1'b0;
      irq_pin_oe_n <= 1'b1;
    end else begin
      irq_pin_out  <= 1'b0;
      irq_pin_oe_n <= ~(|pend);
    end
  end

  // ==========================================================================
  // One second timer
  logic [11:0] frm_cnt;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frm_cnt        <= 12'h000;
      one_second_out <= 1'b0;
      sec_tick       <= 1'b0;
    end else begin
      sec_tick <= 1'b0;
      if (frame_start) begin
        if (frm_cnt == tmo_pkg::HALF_SEC_FRAMES - 12'd1) begin
          frm_cnt        <= 12'h000;
          one_second_out <= ~one_second_out;
          sec_tick       <= ~one_second_out;
        end else begin
          frm_cnt <= frm_cnt + 12'd1;
        end
      end
    end
  end

  // ==========================================================================
  // Data link: flag and message shifted one bit every second frame
  logic        fdl_phase;
  logic [15:0] fdl_shift;
  logic [3:0]  fdl_cnt;
  logic        fdl_bit;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fdl_phase <= 1'b0;
      fdl_shift <= {tmo_pkg::FLAG_BYTE, tmo_pkg::BOM_RESET};
      fdl_cnt   <= 4'h0;
      fdl_bit   <= 1'b1;
      bom_done  <= 1'b0;
    end else begin
      bom_done <= 1'b0;
      if (frame_start) begin
        fdl_phase <= ~fdl_phase;
        if (fdl_phase) begin
          fdl_bit <= fdl_shift[15];
          fdl_cnt <= fdl_cnt + 4'h1;
          if (fdl_cnt == tmo_pkg::BOM_WORD_LAST) begin
            fdl_shift <= {tmo_pkg::FLAG_BYTE, bit_oriented_message};
            bom_done  <= ctrl[tmo_pkg::CTRL_BME_BIT];
          end else begin
            fdl_shift <= {fdl_shift[14:0], 1'b0};
          end
        end
      end
    end
  end

  // Pass-through stays combinational so the external HDLC timing is kept
  assign link_data_out = ctrl[tmo_pkg::CTRL_BME_BIT] ? fdl_bit
                                                       : link_data_in;

  // ==========================================================================
  // Transmit stream multiplexer and loop code generator
  logic [7:0] bit_cnt;
  logic [2:0] code_pos;
  logic [2:0] code_len;
  logic [4:0] code_pat;
  logic       pcm_slot;
  logic       code_bit;
  logic [7:0] slot_idx;

  assign slot_idx = frame_start ? 8'h00 : bit_cnt;
  assign pcm_slot = (slot_idx[4:3] != 2'b11); // Every fourth channel is not trunk
  assign code_len = (mode == tmo_pkg::TMO_CODE_UP) ? tmo_pkg::CODE_UP_LEN : tmo_pkg::CODE_DOWN_LEN;
  assign code_pat = (mode == tmo_pkg::TMO_CODE_UP) ? tmo_pkg::CODE_UP_PAT : tmo_pkg::CODE_DOWN_PAT;
  assign code_bit = (code_pos < code_len) ? code_pat[code_len - 3'd1 - code_pos] : 1'b0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_cnt     <= 8'h00;
      code_pos    <= 3'h0;
      tx_data_out <= 1'b1;
    end else if (bit_rise) begin
      bit_cnt <= slot_idx + 8'h01;
      case (mode)
        tmo_pkg::TMO_NORMAL: begin
          tx_data_out <= pin_lvl[3];
        end
        tmo_pkg::TMO_PAYLOAD: begin
          tx_data_out <= pin_lvl[4];
        end
        default: begin
          if (pcm_slot) begin
            tx_data_out <= code_bit;
            code_pos    <= (code_pos >= code_len - 3'd1) ? 3'h0 : code_pos + 3'd1;
          end else begin
            tx_data_out <= pin_lvl[3];
          end
        end
      endcase
    end else if (frame_start) begin
      bit_cnt <= 8'h00;
    end
  end

endmodule // tmo_output_paths

// ==== rtl/tmo_pkg.sv ====
// Package for the T1 monitor output paths block: register map, fields, timing.
// Assumes a 25 MHz system clock and an APB master with 32-bit data.
package tmo_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] BOM_OFS       = 8'h04;
  localparam logic [7:0] LOOP_OFS      = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h10;
  localparam logic [7:0] STATE_OFS     = 8'h14;

  // ==========================================================================
  // Field positions and reset values
  localparam int          CTRL_BME_BIT  = 0;
  localparam int          CTRL_ACK_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;
  localparam logic [7:0]  BOM_RESET     = 8'h00;
  localparam logic [1:0]  LOOP_RESET    = 2'h0;
  localparam logic [3:0]  IRQ_MASK_RESET = 4'h0;
  localparam logic [7:0]  FLAG_BYTE     = 8'hFF;
  localparam int          EV_SECOND     = 0;
  localparam int          EV_G1         = 1;
  localparam int          EV_G2         = 2;
  localparam int          EV_BOM_WORD   = 3;

  // ==========================================================================
  // Loopback modes
  typedef enum logic [1:0] {
    TMO_NORMAL     = 2'b00,
    TMO_PAYLOAD    = 2'b01,
    TMO_CODE_UP    = 2'b10,
    TMO_CODE_DOWN  = 2'b11
  } tmo_mode_t;

  // ==========================================================================
  // Frame and timer figures
  localparam int          BITS_PER_FRAME  = 256;
  localparam logic [11:0] HALF_SEC_FRAMES = 12'd4000;
  localparam logic [2:0]  CODE_UP_LEN     = 3'd5;
  localparam logic [4:0]  CODE_UP_PAT     = 5'h01;
  localparam logic [2:0]  CODE_DOWN_LEN   = 3'd3;
  localparam logic [4:0]  CODE_DOWN_PAT   = 5'h01;
  localparam logic [3:0]  BOM_WORD_LAST   = 4'hF;

endpackage

// ==== testbench/testbench.sv ====
// Self-checking bench for the T1 monitor output paths over APB.
// Assumes the far side model and the bound checker.
`timescale 1ns/1ps

module testbench;
  // ==========================================================
  // Signals
  logic        sys_clk = 1'b0;
  logic        rst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, bit_clock_in, frame_pulse_n_in, link_data_in;
  logic        link_data_out, tx_data_normal_in, tx_data_loopback_in, tx_data_out;
  logic        one_second_out, irq_pin_out, irq_pin_oe_n, irq_line, e;
  logic [3:0]  g1_sources = 4'h0;
  logic [3:0]  g2_sources = 4'h0;
  logic        fast = 1'b1;
  logic        lvl = 1'b1;
  logic [15:0] sh;
  logic [8:0]  ones;
  int          err_total, num_checks, fcnt, f0, n;
  int          lo[4] = '{256, 0, 30, 55};
  int          hi[4] = '{256, 0, 45, 70};
  // Open drain pin with pull-up
  wire         irq_wire = irq_pin_oe_n ? 1'b1 : irq_pin_out;

  tmo_output_paths i_tmo_output_paths (.*);
  tmo_far_side i_tmo_far_side (.*);

  always #20 sys_clk = ~sys_clk;
  always @(negedge frame_pulse_n_in) fcnt++;

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic late();
    err_total++;
    $display("unexpected wait expected done seen timeout");
    print_verdict();
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) late();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, q);
  endtask

  task automatic frames(input int k);
    int t;
    t = fcnt + k;
    n = 0;
    while (fcnt < t && n < 40000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 40000) late();
  endtask

  task automatic src(input int k, input logic on);
    @(posedge sys_clk);
    g1_sources <= {4{on && k == 0}};
    g2_sources <= {4{on && k == 1}};
  endtask

  task automatic oe(input logic ex, input string nm);
    repeat (8) @(posedge sys_clk);
    chk(nm, {31'h0, ex}, {31'h0, irq_wire});
  endtask

  task automatic sec(input logic lv);
    n = 0;
    while (one_second_out !== lv && n < 40000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 40000) late();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(tmo_pkg::CTRL_OFS, 32'h0, "ctrl reset");
    rd(tmo_pkg::BOM_OFS, 32'h0, "message reset");
    rd(tmo_pkg::LOOP_OFS, 32'h0, "loop reset");
    rd(tmo_pkg::IRQ_MASK_OFS, 32'h0, "mask reset");
    rd(tmo_pkg::IRQ_STAT_OFS, 32'h0, "status reset");
    rd(8'h18, 32'h0, "unmapped data");
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'b1, tmo_pkg::BOM_OFS, 32'hFFFFFF72);
    rd(tmo_pkg::BOM_OFS, 32'h72, "message word");
    repeat (40) begin
      @(negedge sys_clk);
      chk("pass through", {31'h0, link_data_in}, {31'h0, link_data_out});
    end
    apb(1'b1, tmo_pkg::CTRL_OFS, 32'h1);
    e = 1'b0;
    for (int i = 0; i < 80; i++) begin
      frames(1);
      if (i[0]) sh = {sh[14:0], link_data_out};
      if (sh === {tmo_pkg::FLAG_BYTE, 8'h72}) e = 1'b1;
    end
    chk("flag and message", 32'h1, {31'h0, e});
    rd(tmo_pkg::IRQ_STAT_OFS, 32'h8, "word sent");
    chk("masked line", 32'h0, {31'h0, irq_line});
    apb(1'b1, tmo_pkg::IRQ_MASK_OFS, 32'h8);
    repeat (2) @(posedge sys_clk);
    chk("unmasked line", 32'h1, {31'h0, irq_line});
    apb(1'b1, tmo_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, tmo_pkg::IRQ_STAT_OFS, 32'h8);
    repeat (2) @(posedge sys_clk);
    chk("cleared line", 32'h0, {31'h0, irq_line});
    rd(tmo_pkg::IRQ_STAT_OFS, 32'h0, "status cleared");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, tmo_pkg::CTRL_OFS, 32'h2);
      frames(2);
      src(k, 1'b1);
      oe(1'b0, "request");
      chk("pin level", 32'h0, {31'h0, irq_pin_out});
      rd(tmo_pkg::IRQ_STAT_OFS, 32'h2 << k, "group status");
      apb(1'b1, tmo_pkg::CTRL_OFS, 32'h0);
      frames(2);
      oe(1'b1, "acknowledge");
      apb(1'b1, tmo_pkg::CTRL_OFS, 32'h2);
      frames(2);
      oe(1'b1, "no rearm");
      src(k, 1'b0);
      frames(2);
      src(k, 1'b1);
      oe(1'b0, "rearmed");
      apb(1'b1, tmo_pkg::CTRL_OFS, 32'h0);
      src(k, 1'b0);
      frames(2);
      oe(1'b1, "released");
      apb(1'b1, tmo_pkg::IRQ_STAT_OFS, 32'hF);
    end
    @(posedge sys_clk);
    fast <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk);
      lvl <= (m < 2);
      apb(1'b1, tmo_pkg::LOOP_OFS, 32'(m));
      frames(1);
      // Skip the frame's first bits while the new mode settles
      repeat (24) @(posedge sys_clk);
      ones = 9'h0;
      repeat (256) begin
        repeat (12) @(posedge sys_clk);
        ones = ones + {8'h0, tx_data_out};
      end
      chk("ones in frame", 32'h1, {31'h0, ones >= lo[m] && ones <= hi[m]});
    end
    @(posedge sys_clk);
    fast <= 1'b1;
    sec(1'b1);
    f0 = fcnt;
    sec(1'b0);
    chk("high half", {20'h0, tmo_pkg::HALF_SEC_FRAMES}, fcnt - f0);
    rd(tmo_pkg::IRQ_STAT_OFS, 32'h1, "second tick");
    print_verdict();
  end
endmodule // testbench

// ==== testbench/tmo_far_side.sv ====
// Far side model: bit clock, frame pulse and system data streams.
// Assumes 25 MHz sys_clk; twelve cycles make one bit, near 2.048 MHz.
`timescale 1ns/1ps

module tmo_far_side (
  input  wire logic sys_clk,
  input  wire logic fast,
  input  wire logic lvl,
  output logic      bit_clock_in,
  output logic      frame_pulse_n_in,
  output logic      link_data_in,
  output logic      tx_data_normal_in,
  output logic      tx_data_loopback_in
);
  // ==========================================================
  // Timing sources
  logic [3:0] ph = 4'h0;
  logic [7:0] bcnt = 8'h00;
  logic [5:0] lcnt = 6'h00;

  initial begin
    bit_clock_in = 1'b0;
    frame_pulse_n_in = 1'b1;
    link_data_in = 1'b0;
    tx_data_normal_in = 1'b0;
    tx_data_loopback_in = 1'b1;
  end

  always @(posedge sys_clk) begin
    ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
    lcnt <= lcnt + 6'h1;
    link_data_in <= lcnt[5] ^ lcnt[2];
    if (ph == 4'h0) begin
      bit_clock_in <= 1'b1;
      bcnt <= bcnt + 8'h1;
    end
    if (ph == 4'h6) begin
      bit_clock_in <= 1'b0;
      tx_data_normal_in <= lvl;
      tx_data_loopback_in <= ~lvl;
    end
    // Short frames only to reach long frame counts in time
    if (fast)
      frame_pulse_n_in <= lcnt[2];
    else if (ph == 4'h0)
      frame_pulse_n_in <= (bcnt != 8'hFF);
  end
endmodule // tmo_far_side

// ==== testbench/tmo_output_paths_asserts.sv ====
// Checker for the T1 monitor output paths, bound to the top module.
// Assumes one sys_clk domain and an active high async rst.
`timescale 1ns/1ps

module tmo_output_paths_asserts (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        bit_clock_in,
  input wire logic        frame_pulse_n_in,
  input wire logic        link_data_in,
  input wire logic        link_data_out,
  input wire logic        tx_data_out,
  input wire logic        one_second_out,
  input wire logic        irq_pin_out,
  input wire logic        irq_pin_oe_n
);
  // ==========================================================
  // Helper state
  logic        bme_q, ack_q, fp_d, bc_d, seen;
  logic [3:0]  fp_age, bc_age;
  logic [12:0] nfr;
  wire         wr_ctrl = psel && penable && pready && pwrite && paddr == tmo_pkg::CTRL_OFS;
  wire         fp_fall = fp_d && !frame_pulse_n_in;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bme_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (wr_ctrl) begin
      bme_q <= pwdata[tmo_pkg::CTRL_BME_BIT];
      ack_q <= pwdata[tmo_pkg::CTRL_ACK_BIT];
    end
  end

  // Ages start at zero so a rise seen at reset release is covered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fp_d   <= 1'b1;
      bc_d   <= 1'b1;
      fp_age <= 4'h0;
      bc_age <= 4'h0;
    end else begin
      fp_d   <= frame_pulse_n_in;
      bc_d   <= bit_clock_in;
      fp_age <= fp_fall ? 4'h0 : fp_age + {3'h0, fp_age != 4'hF};
      bc_age <= (bit_clock_in && !bc_d) ? 4'h0 : bc_age + {3'h0, bc_age != 4'hF};
    end
  end

  // First half period after reset is not judged
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nfr  <= 13'h0;
      seen <= 1'b0;
    end else if ($changed(one_second_out)) begin
      nfr  <= 13'h0;
      seen <= 1'b1;
    end else if (fp_fall) begin
      nfr  <= nfr + 13'h1;
    end
  end

  // ==========================================================
  // Assertions
  sequence s_wait;
    !pready ##1 pready;
  endsequence

  chk_apb_wait: assert property (psel && $rose(penable) |-> s_wait)
    else $error("pready not in second access cycle");
  chk_apb_error: assert property (psel && penable && pready
    |-> pslverr == (paddr > tmo_pkg::STATE_OFS)) else $error("bad slave error");
  chk_link_pass: assert property (!bme_q |-> link_data_out == link_data_in)
    else $error("link input not passed through");
  chk_link_frame: assert property (bme_q && $past(bme_q) && $changed(link_data_out)
    |-> fp_age >= 4'h3 && fp_age <= 4'h5) else $error("message bit off frame");
  chk_irq_low: assert property (irq_pin_out == 1'b0)
    else $error("interrupt pin driven high");
  chk_irq_ack: assert property (!ack_q && fp_fall |-> ##[1:20] irq_pin_oe_n)
    else $error("interrupt not released");
  chk_irq_cause: assert property ($fell(irq_pin_oe_n) |-> ack_q)
    else $error("request while acknowledge low");
  chk_sec_period: assert property ($changed(one_second_out) && seen
    |-> nfr == {1'b0, tmo_pkg::HALF_SEC_FRAMES}) else $error("bad half period");
  chk_tx_bit: assert property ($changed(tx_data_out) |-> bc_age <= 4'h7)
    else $error("transmit bit off clock");
  chk_reset_idle: assert property (disable iff (1'b0) rst
    |-> irq_pin_oe_n && !pready && tx_data_out && !one_second_out) else $error("not idle");
endmodule // tmo_output_paths_asserts

bind tmo_output_paths tmo_output_paths_asserts u_chk (.*);
